// >>> hdl/ofd_map.vh
// Purpose: constants for the operand field decoder
// Assumes: included by ofd_operand_decode.v only
// Notes:   register offsets are byte addresses on the plain port
`ifndef OFD_MAP_VH
`define OFD_MAP_VH
// ************************************************
// register offsets
// ************************************************
`define OFD_A_CTRL     8'h00
`define OFD_A_FADDR    8'h04
`define OFD_A_LIT      8'h08
`define OFD_A_SLIT     8'h0c
`define OFD_A_PADDR    8'h10
`define OFD_A_BIT      8'h14
`define OFD_A_MAC      8'h18
`define OFD_A_WSEL     8'h1c
`define OFD_A_STAT     8'h20
`define OFD_A_DEC      8'h24
`define OFD_A_PF       8'h28
`define OFD_A_MUL      8'h2c
`define OFD_A_W13      8'h30
`define OFD_A_EXT      8'h34
// ************************************************
// field positions
// ************************************************
`define OFD_CT_RNG     4:0
`define OFD_CT_SIZE    1:0
`define OFD_CT_ACC     2
`define OFD_CT_AWB     3
`define OFD_CT_FW0     4
`define OFD_MAC_RNG    17:0
`define OFD_XMODE      3:0
`define OFD_YMODE      7:4
`define OFD_XD         9:8
`define OFD_YD         11:10
`define OFD_MPAIR      14:12
`define OFD_SQ         17:16
`define OFD_WS_RNG     22:0
`define OFD_WSRC       3:0
`define OFD_WDST       7:4
`define OFD_WBASE      11:8
`define OFD_DIVM       15:12
`define OFD_DIVN       19:16
`define OFD_DIVMODE    22:20
`define OFD_AR_RNG     4:0
`define OFD_DS_RNG     8:5
`define OFD_HI16       31:16
`define OFD_LO16       15:0
`define OFD_Y_PF       25:16
// ************************************************
// values and reset values
// ************************************************
`define OFD_FADDR_MAX  16'h1fff
`define OFD_LIT_BMAX   10'h0ff
`define OFD_SZ_NONE    2'h0
`define OFD_SZ_B       2'h1
`define OFD_SZ_W       2'h2
`define OFD_SZ_D       2'h3
`define OFD_W0         4'h0
`define OFD_W4         4'h4
`define OFD_W8         4'h8
`define OFD_W10        4'ha
`define OFD_W12        4'hc
`define OFD_W13        4'hd
`define OFD_AWB_STEP   16'h0002
`define OFD_NPAIR      3'h6
`define OFD_DIV_DIRECT 3'h0
`define OFD_PF_SPAN    4'h7
`define OFD_PF_IDX     4'he
`define OFD_PF_NONE    4'hf
`define OFD_MOD_P6     4'h6
`define OFD_MOD_P4     4'h4
`define OFD_MOD_P2     4'h2
`define OFD_MOD_0      4'h0
`define OFD_SEXT       6
`define OFD_MAC_RST    18'h000ff
`define OFD_Z32        32'h0000_0000
`define OFD_LIT_RNG    9:0
`define OFD_PA_RNG     22:0
`define OFD_BIT_RNG    3:0
`endif

// >>> hdl/ofd_operand_decode.v
// Purpose: operand field decoder with core status flags
// Assumes: single clock, plain register port, read data one cycle late
// Notes:   see ofd_map.vh for offsets and field layout
//          bad fields are stored as written and only raise decode_err_o
//          core flag and write-back events beat same-cycle software writes
//
// What this block does
// - file register ops use w0 as source and as destination, asked or not
// - file register addresses valid only from 0 to 0x1fff
// - bit selector is four bits choosing bit 0 to 15
// - unsigned ten-bit literal max 255 in byte mode, 1023 in word mode
// - 23-bit program address literal must be even
// - accumulator select field picks exactly one of a or b
// - write-back goes to w13 or to [w13] then w13 plus 2
// - five arithmetic flags c, dc, n, ov and sticky zero
// - four dsp flags: overflow and saturate for each accumulator
// - signed ten-bit literal is two's complement, -512 to 511
// - square ops pair one of w4 to w7 with itself
// - multiply ops pick one of six unordered pairs from w4 to w7
// - x prefetch from w8 or w9, post-modify +-2/4/6, w9+w12, none
// - y prefetch from w10 or w11, post-modify +-2/4/6, w11+w12, none
// - x prefetch destination is one of w4 to w7
// - y prefetch destination is one of w4 to w7 by own field
// - divide takes a direct register pair, no indirect modes
// - working register fields address one of sixteen registers
// - no size suffix means word; byte and double only by suffix
`timescale 1ns/1ps
`include "ofd_map.vh"

module ofd_operand_decode #(
	parameter ADDR_W = 8
) (
	input  wire              clk_sys_i,
	input  wire              arst_n_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [31:0]       wdata_i,
	input  wire              wr_i,
	input  wire              rd_i,
	output reg  [31:0]       rdata_o,
	input  wire              alu_we_i,
	input  wire              alu_carry_i,
	input  wire              alu_dcarry_i,
	input  wire              alu_neg_i,
	input  wire              alu_ovf_i,
	input  wire              alu_zero_i,
	input  wire              alu_zsticky_i,
	input  wire              dsp_we_i,
	input  wire [3:0]        dsp_flags_i,
	input  wire              awb_go_i,
	output reg  [4:0]        arith_flags_o,
	output reg  [3:0]        dsp_flags_o,
	output reg  [15:0]       awb_addr_o,
	output reg               awb_we_o,
	output reg               awb_mem_o,
	output reg               decode_err_o
);

// ************************************************
// functions
// ************************************************
// one of w4..w7 from a two-bit selector
function [3:0] w4_sel;
	input [1:0] sel;
	begin
		w4_sel = `OFD_W4 + {2'h0, sel};
	end
endfunction

// prefetch mode to {active, indexed, reg, signed step}
function [9:0] pf_dec;
	input [3:0] mode;
	input [3:0] lo;
	reg   [3:0] k;
	reg   [3:0] stp;
	reg   [3:0] rg;
	begin
		k   = (mode >= `OFD_PF_SPAN) ? mode - `OFD_PF_SPAN : mode;
		rg  = (mode >= `OFD_PF_SPAN) ? lo + 4'h1 : lo;
		stp = `OFD_MOD_0;
		// codes 7 to 13 repeat 0 to 6 on the odd base register
		case (k)
			4'h0: stp = `OFD_MOD_P6;
			4'h1: stp = `OFD_MOD_P4;
			4'h2: stp = `OFD_MOD_P2;
			4'h4: stp = -`OFD_MOD_P6;
			4'h5: stp = -`OFD_MOD_P4;
			4'h6: stp = -`OFD_MOD_P2;
			default: stp = `OFD_MOD_0;
		endcase
		if (mode == `OFD_PF_NONE)
			pf_dec = 10'h000;
		else if (mode == `OFD_PF_IDX)
			pf_dec = {2'b11, rg, `OFD_MOD_0};
		else
			pf_dec = {2'b10, rg, stp};
	end
endfunction

// unordered pair index to {m, n}
function [7:0] pair_dec;
	input [2:0] sel;
	begin
		// codes 6 and 7 name no pair; pair_ok reports them
		case (sel)
			3'h0: pair_dec = {w4_sel(2'h0), w4_sel(2'h1)};
			3'h1: pair_dec = {w4_sel(2'h0), w4_sel(2'h2)};
			3'h2: pair_dec = {w4_sel(2'h0), w4_sel(2'h3)};
			3'h3: pair_dec = {w4_sel(2'h1), w4_sel(2'h2)};
			3'h4: pair_dec = {w4_sel(2'h1), w4_sel(2'h3)};
			3'h5: pair_dec = {w4_sel(2'h2), w4_sel(2'h3)};
			default: pair_dec = 8'h00;
		endcase
	end
endfunction

// ************************************************
// registers
// ************************************************
reg  [4:0]  ctrl_r;
reg  [15:0] faddr_r;
reg  [9:0]  lit_r;
reg  [9:0]  slit_r;
reg  [22:0] paddr_r;
reg  [3:0]  bit_r;
reg  [17:0] mac_r;
reg  [22:0] wsel_r;
reg  [15:0] w13_r;
reg  [31:0] rdata_nxt;

// ************************************************
// decode
// ************************************************
// fields are checked here, never clamped
wire [1:0]  size_eff = (ctrl_r[`OFD_CT_SIZE] == `OFD_SZ_NONE) ?
	`OFD_SZ_W : ctrl_r[`OFD_CT_SIZE];
wire        byte_m   = (size_eff == `OFD_SZ_B);
wire        dword_m  = (size_eff == `OFD_SZ_D);
wire        faddr_ok = (faddr_r <= `OFD_FADDR_MAX);
wire        lit_ok   = !byte_m || (lit_r <= `OFD_LIT_BMAX);
wire        paddr_ok = (paddr_r[0] == 1'b0);
wire        pair_ok  = (mac_r[`OFD_MPAIR] < `OFD_NPAIR);
wire        div_ok   = (wsel_r[`OFD_DIVMODE] == `OFD_DIV_DIRECT);
wire [9:0]  x_pf     = pf_dec(mac_r[`OFD_XMODE], `OFD_W8);
wire [9:0]  y_pf     = pf_dec(mac_r[`OFD_YMODE], `OFD_W10);
wire [7:0]  mpair    = pair_dec(mac_r[`OFD_MPAIR]);
wire [3:0]  sq_reg   = w4_sel(mac_r[`OFD_SQ]);
wire [3:0]  xd_reg   = w4_sel(mac_r[`OFD_XD]);
wire [3:0]  yd_reg   = w4_sel(mac_r[`OFD_YD]);
wire [15:0] bit_mask = 16'h0001 << bit_r;
wire [15:0] slit_ext = {{`OFD_SEXT{slit_r[9]}}, slit_r};

// file ops: source is always w0, destination w0 whether asked or not
wire [3:0]  fsrc_reg = `OFD_W0;
wire [3:0]  fdst_reg = ctrl_r[`OFD_CT_FW0] ? `OFD_W0 : `OFD_W0;
// any bad field raises the error flag one cycle later
wire        all_ok   = faddr_ok && lit_ok && paddr_ok && pair_ok && div_ok;

// decoded view: flags, file regs, accumulator and write-back choice
wire [31:0] dec_word = {14'h0000, fdst_reg, fsrc_reg,
	ctrl_r[`OFD_CT_FW0], ctrl_r[`OFD_CT_AWB], ctrl_r[`OFD_CT_ACC],
	dword_m, byte_m, div_ok, pair_ok, paddr_ok, lit_ok, faddr_ok};
wire [31:0] pf_word  = {6'h00, y_pf, 6'h00, x_pf};
wire [31:0] mul_word = {4'h0, wsel_r[`OFD_WBASE], `OFD_W13,
	yd_reg, xd_reg, sq_reg, mpair};
// literal widened here so software sees the sign directly
wire [31:0] ext_word = {slit_ext, bit_mask};

// ************************************************
// write decode
// ************************************************
// software and core share these two, so their strobes are named
wire        wr_stat  = wr_i && (addr_i == `OFD_A_STAT);
wire        wr_w13   = wr_i && (addr_i == `OFD_A_W13);

// ************************************************
// read port
// ************************************************
// reads have no side effects, so a mux ahead of one flop is enough
always @*
begin
	rdata_nxt = `OFD_Z32;
	// zero outside the read cycle so stale data never shows
	if (!rd_i)
		rdata_nxt = `OFD_Z32;
	else if (addr_i == `OFD_A_CTRL)
		rdata_nxt = {27'h0, ctrl_r};
	else if (addr_i == `OFD_A_FADDR)
		rdata_nxt = {16'h0000, faddr_r};
	else if (addr_i == `OFD_A_LIT)
		rdata_nxt = {22'h0, lit_r};
	else if (addr_i == `OFD_A_SLIT)
		rdata_nxt = {22'h0, slit_r};
	else if (addr_i == `OFD_A_PADDR)
		rdata_nxt = {9'h000, paddr_r};
	else if (addr_i == `OFD_A_BIT)
		rdata_nxt = {28'h0, bit_r};
	else if (addr_i == `OFD_A_MAC)
		rdata_nxt = {14'h0, mac_r};
	else if (addr_i == `OFD_A_WSEL)
		rdata_nxt = {9'h000, wsel_r};
	// live flags: a read shows the last core or software update
	else if (addr_i == `OFD_A_STAT)
		rdata_nxt = {23'h0, dsp_flags_o, arith_flags_o};
	// views from here on are read-only, except w13, which software can load
	else if (addr_i == `OFD_A_DEC)
		rdata_nxt = dec_word;
	else if (addr_i == `OFD_A_PF)
		rdata_nxt = pf_word;
	else if (addr_i == `OFD_A_MUL)
		rdata_nxt = mul_word;
	else if (addr_i == `OFD_A_W13)
		rdata_nxt = {16'h0000, w13_r};
	else if (addr_i == `OFD_A_EXT)
		rdata_nxt = ext_word;
	else
		rdata_nxt = `OFD_Z32;
end

// one flop stage gives the one-cycle read latency

always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
		rdata_o <= `OFD_Z32;
	else
		rdata_o <= rdata_nxt;
end

// ************************************************
// field registers
// ************************************************
always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
	begin
		ctrl_r  <= 5'h00;
		faddr_r <= 16'h0000;
		lit_r   <= 10'h000;
		slit_r  <= 10'h000;
		paddr_r <= 23'h000000;
		bit_r   <= 4'h0;
		// both prefetch modes reset to none, so a stray op moves nothing
		mac_r   <= `OFD_MAC_RST;
		wsel_r  <= 23'h000000;
	end
	else if (wr_i)
	begin
		// views other than w13, and unmapped offsets, fall through, so writes there drop
		if (addr_i == `OFD_A_CTRL)
			ctrl_r <= wdata_i[`OFD_CT_RNG];
		else if (addr_i == `OFD_A_FADDR)
			faddr_r <= wdata_i[`OFD_LO16];
		else if (addr_i == `OFD_A_LIT)
			lit_r <= wdata_i[`OFD_LIT_RNG];
		else if (addr_i == `OFD_A_SLIT)
			slit_r <= wdata_i[`OFD_LIT_RNG];
		else if (addr_i == `OFD_A_PADDR)
			paddr_r <= wdata_i[`OFD_PA_RNG];
		else if (addr_i == `OFD_A_BIT)
			bit_r <= wdata_i[`OFD_BIT_RNG];
		else if (addr_i == `OFD_A_MAC)
			mac_r <= wdata_i[`OFD_MAC_RNG];
		else if (addr_i == `OFD_A_WSEL)
			wsel_r <= wdata_i[`OFD_WS_RNG];
	end
end

// ************************************************
// status flags
// ************************************************
// a core update in the same cycle as a software write wins
always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
		arith_flags_o <= 5'h00;
	else if (alu_we_i)
	begin
		arith_flags_o[3:0] <= {alu_ovf_i, alu_neg_i, alu_dcarry_i, alu_carry_i};
		// in sticky ops the zero flag only clears, so multi-word results chain
		arith_flags_o[4]   <= alu_zsticky_i ? (arith_flags_o[4] & alu_zero_i) :
			alu_zero_i;
	end
	else if (wr_stat)
		arith_flags_o <= wdata_i[`OFD_AR_RNG];
end

always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
		dsp_flags_o <= 4'h0;
	else if (dsp_we_i)
		dsp_flags_o <= dsp_flags_i;
	else if (wr_stat)
		dsp_flags_o <= wdata_i[`OFD_DS_RNG];
end

// ************************************************
// accumulator write-back
// ************************************************
// hardware post-increment beats a same-cycle software load of w13
always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
	begin
		w13_r      <= 16'h0000;
		awb_addr_o <= 16'h0000;
		awb_we_o   <= 1'b0;
		awb_mem_o  <= 1'b0;
	end
	else
	begin
		// pulse follows every event, whatever the mode
		awb_we_o <= awb_go_i;
		if (awb_go_i && ctrl_r[`OFD_CT_AWB])
		begin
			awb_addr_o <= w13_r;
			awb_mem_o  <= 1'b1;
			w13_r      <= w13_r + `OFD_AWB_STEP;
		end
		// register mode leaves w13 untouched
		else if (awb_go_i)
		begin
			awb_addr_o <= {12'h000, `OFD_W13};
			awb_mem_o  <= 1'b0;
		end
		else if (wr_w13)
			w13_r <= wdata_i[`OFD_LO16];
	end
end

// ************************************************
// error flag
// ************************************************
// registered so the output comes from a flop; lags the fields a cycle
always @(posedge clk_sys_i or negedge arst_n_i)
begin
	if (!arst_n_i)
		decode_err_o <= 1'b0;
	else
		decode_err_o <= !all_ok;
end

endmodule

// >>> tb/ofd_asserts.sv
// Purpose: port checks for the operand field decoder
// Assumes: bound to ofd_operand_decode, one clock domain
// Notes:   relations span one or two cycles only
`timescale 1ns/1ps
module ofd_asserts #(
	parameter ADDR_W = 8
) (
	input wire logic              clk_sys_i,
	input wire logic              arst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0]       wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [31:0]       rdata_o,
	input wire logic              alu_we_i,
	input wire logic              alu_carry_i,
	input wire logic              alu_dcarry_i,
	input wire logic              alu_neg_i,
	input wire logic              alu_ovf_i,
	input wire logic              alu_zero_i,
	input wire logic              alu_zsticky_i,
	input wire logic              dsp_we_i,
	input wire logic [3:0]        dsp_flags_i,
	input wire logic              awb_go_i,
	input wire logic [4:0]        arith_flags_o,
	input wire logic [3:0]        dsp_flags_o,
	input wire logic [15:0]       awb_addr_o,
	input wire logic              awb_we_o,
	input wire logic              awb_mem_o,
	input wire logic              decode_err_o
);
	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	wire [4:0] alu_vec = {alu_zero_i, alu_ovf_i, alu_neg_i, alu_dcarry_i, alu_carry_i};
	awb_pulse_a: assert property (awb_go_i |=> awb_we_o)
		else $error("write-back pulse missing");
	awb_idle_a: assert property (!awb_go_i |=> !awb_we_o)
		else $error("write-back pulse without cause");
	awb_reg_a: assert property (awb_we_o && !awb_mem_o |-> awb_addr_o == 16'h000d)
		else $error("register write-back not to w13");
	awb_step_a: assert property ((awb_we_o && awb_mem_o) ##1 (awb_we_o && awb_mem_o)
		|-> awb_addr_o == $past(awb_addr_o) + 16'h0002) else $error("w13 step not two");
	flag_load_a: assert property (alu_we_i && !alu_zsticky_i |=> arith_flags_o == $past(alu_vec))
		else $error("arith flags not loaded");
	zero_sticky_a: assert property (alu_we_i && alu_zsticky_i
		|=> arith_flags_o[4] == ($past(arith_flags_o[4]) && $past(alu_zero_i))) else $error("sticky zero");
	dsp_load_a: assert property (dsp_we_i |=> dsp_flags_o == $past(dsp_flags_i))
		else $error("dsp flags not loaded");
	flags_hold_a: assert property (!alu_we_i && !wr_i |=> $stable(arith_flags_o))
		else $error("arith flags moved unasked");
	rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	awb_twice_c: cover property ((awb_we_o && awb_mem_o) [*2]);
	sticky_c: cover property (alu_we_i && alu_zsticky_i && !alu_zero_i);
	dsp_c: cover property (dsp_we_i);
endmodule
bind ofd_operand_decode ofd_asserts #(.ADDR_W(ADDR_W)) u_chk (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .alu_we_i(alu_we_i),
	.alu_carry_i(alu_carry_i), .alu_dcarry_i(alu_dcarry_i), .alu_neg_i(alu_neg_i),
	.alu_ovf_i(alu_ovf_i), .alu_zero_i(alu_zero_i), .alu_zsticky_i(alu_zsticky_i),
	.dsp_we_i(dsp_we_i), .dsp_flags_i(dsp_flags_i), .awb_go_i(awb_go_i),
	.arith_flags_o(arith_flags_o), .dsp_flags_o(dsp_flags_o), .awb_addr_o(awb_addr_o),
	.awb_we_o(awb_we_o), .awb_mem_o(awb_mem_o), .decode_err_o(decode_err_o));

// >>> tb/ofd_fetch_model.sv
// Purpose: core side that raises flag updates and write-back events
// Assumes: tasks called from the bench between clock edges
// Notes:   flag values go inverted once the pulse ends
`timescale 1ns/1ps
module ofd_fetch_model (
	input  wire logic       clk_i,
	output logic            alu_we_o = 1'b0,
	output logic [5:0]      alu_val_o = 6'h00,
	output logic            dsp_we_o = 1'b0,
	output logic [3:0]      dsp_val_o = 4'h0,
	output logic            awb_go_o = 1'b0
);
	// ************************************************
	// events
	// ************************************************
	// v is {sticky, zero, ovf, neg, dcarry, carry}
	task alu(input logic [5:0] v);
		@(posedge clk_i);
		alu_we_o <= 1'b1;
		alu_val_o <= v;
		@(posedge clk_i);
		alu_we_o <= 1'b0;
		alu_val_o <= ~v;
	endtask
	task dsp(input logic [3:0] v);
		@(posedge clk_i);
		dsp_we_o <= 1'b1;
		dsp_val_o <= v;
		@(posedge clk_i);
		dsp_we_o <= 1'b0;
		dsp_val_o <= ~v;
	endtask
	// back to back events stress the w13 step
	task acc_writeback_dest(input int n);
		@(posedge clk_i);
		awb_go_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		awb_go_o <= 1'b0;
	endtask
endmodule

// >>> tb/test_operand_field_decode.sv
// Purpose: register-level tests of the operand field decoder
// Assumes: read data valid only in the cycle after the read strobe
// Notes:   a second reset in mid-run checks the cleared state
`timescale 1ns/1ps
module test_operand_field_decode;
	logic        clk_sys_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        alu_we_i, dsp_we_i, awb_go_i, awb_we_o, awb_mem_o, decode_err_o;
	logic [5:0]  alu_val;
	logic [3:0]  dsp_flags_i, dsp_flags_o;
	logic [4:0]  arith_flags_o;
	logic [15:0] awb_addr_o;
	int          miscompares = 0;
	int          checked = 0;
	ofd_fetch_model fm (.clk_i(clk_sys_i), .alu_we_o(alu_we_i), .alu_val_o(alu_val),
		.dsp_we_o(dsp_we_i), .dsp_val_o(dsp_flags_i), .awb_go_o(awb_go_i));
	ofd_operand_decode #(.ADDR_W(8)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.alu_we_i(alu_we_i), .alu_carry_i(alu_val[0]), .alu_dcarry_i(alu_val[1]),
		.alu_neg_i(alu_val[2]), .alu_ovf_i(alu_val[3]), .alu_zero_i(alu_val[4]),
		.alu_zsticky_i(alu_val[5]), .dsp_we_i(dsp_we_i), .dsp_flags_i(dsp_flags_i),
		.awb_go_i(awb_go_i), .arith_flags_o(arith_flags_o), .dsp_flags_o(dsp_flags_o),
		.awb_addr_o(awb_addr_o), .awb_we_o(awb_we_o), .awb_mem_o(awb_mem_o),
		.decode_err_o(decode_err_o));
	// ************************************************
	// tasks
	// ************************************************
	initial forever #10 clk_sys_i = ~clk_sys_i;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		wdata_i <= ~d;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o & m, e);
	endtask
	// error flag lags the stored field by one cycle
	task werr(input logic [7:0] a, input logic [31:0] d, input logic e);
		wr(a, d);
		@(posedge clk_sys_i);
		#1 chk({31'h0, decode_err_o}, {31'h0, e});
	endtask
	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		miscompares++;
		report_and_stop;
	end
	// ************************************************
	// tests
	// ************************************************
	initial
	begin
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		addr_i <= 8'h00;
		wdata_i <= 32'h0;
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rd(8'h18, 32'hffffffff, 32'h000000ff);
		rd(8'h28, 32'hffffffff, 32'h0);
		rd(8'h3c, 32'hffffffff, 32'h0);
		$display("test reset done");
		werr(8'h04, 32'h1fff, 1'b0);
		werr(8'h04, 32'h2000, 1'b1);
		werr(8'h04, 32'h0, 1'b0);
		werr(8'h10, 32'h7ffffe, 1'b0);
		werr(8'h10, 32'h1, 1'b1);
		werr(8'h10, 32'h0, 1'b0);
		werr(8'h18, 32'h060ff, 1'b1);
		werr(8'h18, 32'h050ff, 1'b0);
		werr(8'h1c, 32'h100000, 1'b1);
		werr(8'h1c, 32'hfffff, 1'b0);
		werr(8'h00, 32'h1, 1'b0);
		werr(8'h08, 32'h100, 1'b1);
		werr(8'h00, 32'h0, 1'b0);
		werr(8'h08, 32'h3ff, 1'b0);
		$display("test fields done");
		wr(8'h00, 32'h3);
		rd(8'h24, 32'h60, 32'h40);
		wr(8'h00, 32'h14);
		rd(8'h24, 32'h3e2a0, 32'h280);
		wr(8'h14, 32'hf);
		rd(8'h34, 32'hffff, 32'h8000);
		wr(8'h0c, 32'h200);
		rd(8'h34, 32'hffff0000, 32'hfe000000);
		wr(8'h18, 32'h3563b);
		rd(8'h2c, 32'hffffff, 32'hd56767);
		rd(8'h28, 32'h03ff03ff, 32'h02a0029a);
		wr(8'h18, 32'h356fe);
		rd(8'h28, 32'h03ff03ff, 32'h00000390);
		$display("test views done");
		fm.alu(6'b010101);
		#1 chk(arith_flags_o, 32'h15);
		fm.alu(6'b100101);
		#1 chk(arith_flags_o, 32'h05);
		fm.alu(6'b110101);
		#1 chk(arith_flags_o, 32'h05);
		fm.dsp(4'ha);
		#1 chk(dsp_flags_o, 32'ha);
		rd(8'h20, 32'h1ff, 32'h145);
		wr(8'h20, 32'h1ff);
		rd(8'h20, 32'h1ff, 32'h1ff);
		$display("test flags done");
		wr(8'h00, 32'h8);
		wr(8'h30, 32'h100);
		fm.acc_writeback_dest(2);
		#1 chk({awb_we_o, awb_mem_o, awb_addr_o}, 32'h30102);
		rd(8'h30, 32'hffff, 32'h104);
		wr(8'h00, 32'h0);
		fm.acc_writeback_dest(1);
		#1 chk({awb_we_o, awb_mem_o, awb_addr_o}, 32'h2000d);
		$display("test write-back done");
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		#1 chk({awb_we_o, awb_mem_o, awb_addr_o}, 32'h0);
		chk({dsp_flags_o, arith_flags_o}, 32'h0);
		rd(8'h30, 32'hffff, 32'h0);
		rd(8'h18, 32'hffffffff, 32'h000000ff);
		$display("test second reset done");
		report_and_stop;
	end
endmodule
